// ==== core/por_ready_defines.vh ====
// constants for the power-on reset and register readiness block
`ifndef POR_READY_DEFINES_VH
`define POR_READY_DEFINES_VH

`define ADDR_W 8
`define ADDR_STATUS 8'h00
`define ADDR_LOOP_CTRL 8'h30
`define ADDR_POST_DIV_A0 8'h86
`define ADDR_POST_DIV_A1 8'h87
`define ADDR_POST_DIV_A2 8'h88
`define ADDR_POST_DIV_B0 8'h89
`define ADDR_POST_DIV_B1 8'h8A
`define ADDR_POST_DIV_B2 8'h8B
`define ADDR_REVISION 8'hC6
`define ADDR_LOOP_RANGE 8'hED

`define STATUS_READY_BIT 7
`define LOOP_CTRL_RSVD_MASK 8'hFC
`define LOOP_CTRL_RESET 8'h00
`define LOOP_RANGE_RESET 8'h00
`define POST_DIV_RESET 24'h000000
`define REVISION_CODE 8'h5A
`define UNMAPPED_DATA 8'h00
`define RDATA_RESET 8'h00

// initialisation time in ns and its length in 4 ns clock cycles
`define INIT_TIME_NS 55000000
`define CLK_PERIOD_NS 4
`define INIT_CYCLES (`INIT_TIME_NS / `CLK_PERIOD_NS)

`endif

// ==== core/init_timer.v ====
// counts out post-reset initialisation and raises a done level
`timescale 1ns/1ps
`include "por_ready_defines.vh"
// CNT_W must be wide enough to reach INIT_CYCLES - 1 or done never rises
module init_timer #(
    parameter CNT_W = 24,
    parameter INIT_CYCLES = `INIT_CYCLES
) (
    input wire clk,
    input wire rst_n,
    output reg done
);
    reg [CNT_W-1:0] count_q;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_q <= {CNT_W{1'b0}};
            done <= 1'b0;
        end else if (!done) begin
            if (count_q >= INIT_CYCLES - 1'b1) begin
                done <= 1'b1;
            end else begin
                count_q <= count_q + 1'b1;
            end
        end
    end
endmodule

// ==== core/por_ready.v ====
// reset handling, ready flag and a small register file
//
// Functional notes
// R1: while reset input is low, all internal logic is held in reset.
// R2: outside party must pulse reset once after power-up.
// R3: outside party holds reset low at least 2 ms per assertion.
// R4: host waits 55 ms after release, or until ready flag set.
// R5: after initialisation, status register 0x00 bit 7 reads high.
// R6: loop control 0x30 bits 1:0 reserved, reset value 00.
// R7: loop range selection comes from register 0xED.
// R8: ready flag cleared during reset and on every new assertion.
`timescale 1ns/1ps
`include "por_ready_defines.vh"
module por_ready #(
    parameter CNT_W = 24,
    parameter INIT_CYCLES = `INIT_CYCLES
) (
    // clock and reset
    input wire MCLK,
    input wire ARST_N,
    // register access port
    input wire REG_WR,
    input wire REG_RD,
    input wire [7:0] REG_ADDR,
    input wire [7:0] REG_WDATA,
    output reg [7:0] REG_RDATA,
    output reg REG_RVALID,
    // status and settings to the rest of the device
    output wire READY,
    output wire [7:0] LOOP_RANGE,
    output wire [7:0] LOOP_CTRL,
    output wire [23:0] POST_DIV_A,
    output wire [23:0] POST_DIV_B
);
    reg rst_meta_q;
    reg rst_sync_q;
    wire ready;
    reg [7:0] loop_ctrl_q;
    reg [7:0] loop_range_q;
    reg [23:0] div_a_q;
    reg [23:0] div_b_q;

    // async assert, synchronous release keeps every flop coherent
    always @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    // the timer clears on every assertion, so ready drops at once
    init_timer #(
        .CNT_W(CNT_W),
        .INIT_CYCLES(INIT_CYCLES)
    ) u_timer (
        .clk(MCLK),
        .rst_n(rst_sync_q),
        .done(ready)
    ); // R1 R8

    assign READY = ready; // R5
    assign LOOP_RANGE = loop_range_q; // R7
    assign LOOP_CTRL = loop_ctrl_q;
    assign POST_DIV_A = div_a_q;
    assign POST_DIV_B = div_b_q;

    // one-hot byte hit of a three-byte register, lsb at the low address
    function [2:0] byte_hit;
        input [7:0] addr;
        input [7:0] lo;
        input [7:0] mid;
        input [7:0] hi;
        begin
            byte_hit = 3'h0;
            if (addr == lo) begin
                byte_hit[0] = 1'b1;
            end
            if (addr == mid) begin
                byte_hit[1] = 1'b1;
            end
            if (addr == hi) begin
                byte_hit[2] = 1'b1;
            end
        end
    endfunction

    // replaces the selected bytes, the others keep their value
    function [23:0] put_bytes;
        input [23:0] cur;
        input [2:0] sel;
        input [7:0] val;
        begin
            put_bytes = cur;
            if (sel[0]) begin
                put_bytes[7:0] = val;
            end
            if (sel[1]) begin
                put_bytes[15:8] = val;
            end
            if (sel[2]) begin
                put_bytes[23:16] = val;
            end
        end
    endfunction

    // picks the selected byte of a divider for a read
    function [7:0] get_byte;
        input [23:0] cur;
        input [2:0] sel;
        begin
            get_byte = `UNMAPPED_DATA;
            if (sel[0]) begin
                get_byte = cur[7:0];
            end
            if (sel[1]) begin
                get_byte = cur[15:8];
            end
            if (sel[2]) begin
                get_byte = cur[23:16];
            end
        end
    endfunction

    wire wr_ok;
    wire wr_loop_ctrl;
    wire wr_loop_range;
    wire [2:0] hit_div_a;
    wire [2:0] hit_div_b;
    wire [2:0] wr_div_a;
    wire [2:0] wr_div_b;
    reg [7:0] rd_word;

    // writes before ready are dropped: the device is still initialising
    assign wr_ok = REG_WR & ready;
    assign wr_loop_ctrl = wr_ok & (REG_ADDR == `ADDR_LOOP_CTRL);
    assign wr_loop_range = wr_ok & (REG_ADDR == `ADDR_LOOP_RANGE);
    assign hit_div_a = byte_hit(REG_ADDR, `ADDR_POST_DIV_A0,
        `ADDR_POST_DIV_A1, `ADDR_POST_DIV_A2);
    assign hit_div_b = byte_hit(REG_ADDR, `ADDR_POST_DIV_B0,
        `ADDR_POST_DIV_B1, `ADDR_POST_DIV_B2);
    assign wr_div_a = wr_ok ? hit_div_a : 3'h0;
    assign wr_div_b = wr_ok ? hit_div_b : 3'h0;

    // reserved control bits are never stored, so they always read zero
    always @(posedge MCLK or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            loop_ctrl_q <= `LOOP_CTRL_RESET;
        end else if (wr_loop_ctrl) begin
            loop_ctrl_q <= REG_WDATA & `LOOP_CTRL_RSVD_MASK; // R6
        end
    end

    // pull-in and hold-in range lives here, not in the control register
    always @(posedge MCLK or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            loop_range_q <= `LOOP_RANGE_RESET;
        end else if (wr_loop_range) begin
            loop_range_q <= REG_WDATA; // R7
        end
    end

    // each divider byte is written on its own; no staging of the word
    always @(posedge MCLK or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            div_a_q <= `POST_DIV_RESET;
        end else if (|wr_div_a) begin
            div_a_q <= put_bytes(div_a_q, wr_div_a, REG_WDATA);
        end
    end

    always @(posedge MCLK or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            div_b_q <= `POST_DIV_RESET;
        end else if (|wr_div_b) begin
            div_b_q <= put_bytes(div_b_q, wr_div_b, REG_WDATA);
        end
    end

    // status reads always answer so a polling host sees ready rise
    always @* begin
        rd_word = `UNMAPPED_DATA;
        case (REG_ADDR)
            `ADDR_STATUS: begin
                rd_word[`STATUS_READY_BIT] = ready; // R5
            end
            `ADDR_LOOP_CTRL: begin
                rd_word = loop_ctrl_q; // R6
            end
            `ADDR_LOOP_RANGE: begin
                rd_word = loop_range_q;
            end
            `ADDR_REVISION: begin
                rd_word = `REVISION_CODE;
            end
            default: begin
                if (|hit_div_a) begin
                    rd_word = get_byte(div_a_q, hit_div_a);
                end else if (|hit_div_b) begin
                    rd_word = get_byte(div_b_q, hit_div_b);
                end
            end
        endcase
    end

    always @(posedge MCLK or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            REG_RVALID <= 1'b0;
        end else begin
            REG_RVALID <= REG_RD;
        end
    end

    // read data holds until the next read, so a slow host may take it late
    always @(posedge MCLK or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            REG_RDATA <= `RDATA_RESET;
        end else if (REG_RD) begin
            REG_RDATA <= rd_word;
        end
    end
endmodule

// ==== verif/rst_supervisor.sv ====
// board reset supervisor model
`timescale 1ns/1ps
module rst_supervisor #(parameter HOLD = 8) (
    input wire clk,
    output reg rst_n = 1'b0
);
    // one low pulse a call, whole cycles only
    task pulse;
        begin
            @(posedge clk) #1 rst_n = 1'b0;
            repeat (HOLD) @(posedge clk);
            #1 rst_n = 1'b1;
        end
    endtask
endmodule

// ==== verif/por_ready_checker.sv ====
// port assertions for the reset and ready block
`timescale 1ns/1ps
module por_ready_checker (
    input wire MCLK, ARST_N, REG_WR, REG_RD, REG_RVALID, READY,
    input wire [7:0] REG_ADDR, REG_WDATA, REG_RDATA, LOOP_RANGE, LOOP_CTRL,
    input wire [23:0] POST_DIV_A, POST_DIV_B
);
    default clocking @(posedge MCLK);
    endclocking
    default disable iff (!ARST_N);
    property p_held;
        disable iff (1'b0) !ARST_N |=> !(REG_RVALID | (|LOOP_RANGE)
            | (|LOOP_CTRL) | (|REG_RDATA) | (|POST_DIV_A) | (|POST_DIV_B));
    endproperty
    property p_clear;
        disable iff (1'b0) !ARST_N |=> !READY;
    endproperty
    property p_stat;
        REG_RD && REG_ADDR == 8'h00 |=> REG_RDATA == {$past(READY), 7'h00};
    endproperty
    property p_rsvd;
        LOOP_CTRL[1:0] == 2'b00;
    endproperty
    property p_range;
        REG_WR && READY && REG_ADDR == 8'hED
            |=> LOOP_RANGE == $past(REG_WDATA);
    endproperty
    property p_keep;
        READY |=> READY;
    endproperty
    a_held: assert property (p_held) else $error("not held");
    a_stat: assert property (p_stat) else $error("bad status");
    a_rsvd: assert property (p_rsvd) else $error("reserved set");
    a_range: assert property (p_range) else $error("bad range");
    a_keep: assert property (p_keep) else $error("ready lost");
    a_clear: assert property (p_clear) else $error("ready kept");
    c_stat: cover property (REG_RD && READY);
    c_wr: cover property (REG_WR && READY);
    c_rst: cover property ($rose(ARST_N));
endmodule
bind por_ready por_ready_checker chk (.*);

// ==== verif/por_ready_tb.sv ====
// random and corner tests of the reset and ready block
`timescale 1ns/1ps
`include "por_ready_defines.vh"
module por_ready_tb;
    reg MCLK = 1'b0, REG_WR = 1'b0, REG_RD = 1'b0, rv = 1'b0;
    reg [47:0] dv = 48'h0;
    wire [23:0] POST_DIV_A, POST_DIV_B;
    wire [47:0] pd = {POST_DIV_B, POST_DIV_A};
    reg [7:0] REG_ADDR = 8'h00, REG_WDATA = 8'h00, d = 8'h00, p = 8'h00, v;
    wire ARST_N, REG_RVALID, READY;
    wire [7:0] REG_RDATA, LOOP_RANGE, LOOP_CTRL;
    integer fail_count = 0, n_compared = 0, i, k;
    always #2 MCLK = ~MCLK;
    rst_supervisor sup (.clk(MCLK), .rst_n(ARST_N));
    por_ready #(.INIT_CYCLES(24'h14)) uut (
        .MCLK(MCLK), .ARST_N(ARST_N), .REG_WR(REG_WR), .REG_RD(REG_RD),
        .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
        .REG_RVALID(REG_RVALID), .READY(READY), .LOOP_RANGE(LOOP_RANGE),
        .LOOP_CTRL(LOOP_CTRL), .POST_DIV_A(POST_DIV_A),
        .POST_DIV_B(POST_DIV_B));
    function [7:0] ctrl_exp(input [7:0] x);
        ctrl_exp = x & 8'hFC;
    endfunction
    task chk(input [7:0] s, e);
        begin
            n_compared = n_compared + 1;
            if (s !== e) begin
                fail_count = fail_count + 1;
                $display("mismatch %0t: %h vs %h", $time, s, e);
            end
        end
    endtask
    // both strobes may be set; a read then returns the old value
    task acc(input w, r, input [7:0] a, b);
        begin
            @(posedge MCLK) #1 {REG_WR, REG_RD, REG_ADDR, REG_WDATA} =
                {w, r, a, b};
            @(posedge MCLK) #1 {REG_WR, REG_RD} = 2'b00;
            d = REG_RDATA;
            rv = REG_RVALID;
        end
    endtask
    // polls status, bounded; a timeout ends the run as failed
    task wait_ready;
        begin
            d = 8'h00;
            repeat (2) @(posedge MCLK);
            for (i = 0; i < 40 && !d[7]; i = i + 1)
                acc(1'b0, 1'b1, 8'h00, 8'h00);
            chk(d, 8'h80);
            chk({7'h00, rv}, 8'h01);
            if (!d[7])
                complete_run;
        end
    endtask
    task complete_run;
        begin
            $display("%0d compared, %0d failed", n_compared, fail_count);
            if (fail_count == 0 && n_compared > 0)
                $display("All tests passed");
            else
                $display("Some tests failed");
            $finish;
        end
    endtask
    initial begin
        i = $urandom(73);
        sup.pulse;
        wait_ready;
        for (i = 0; i < 10; i = i + 1) begin
            v = i < 2 ? {8{i[0]}} : 8'($urandom);
            acc(1'b1, 1'b0, 8'hED, v);
            chk({7'h00, rv}, 8'h00);
            acc(1'b1, 1'b1, 8'h30, v);
            chk(d, ctrl_exp(p));
            chk(LOOP_CTRL, ctrl_exp(v));
            chk(LOOP_RANGE, v);
            chk({7'h00, rv}, 8'h01);
            p = v;
        end
        for (k = 0; k < 6; k = k + 1) begin
            v = 8'($urandom);
            dv[8*k +: 8] = v;
            acc(1'b1, 1'b0, 8'h86 + k[7:0], v);
        end
        for (k = 0; k < 6; k = k + 1) begin
            acc(1'b0, 1'b1, 8'h86 + k[7:0], 8'h00);
            chk(d, dv[8*k +: 8]);
            chk(pd[8*k +: 8], dv[8*k +: 8]);
        end
        acc(1'b0, 1'b1, 8'hC6, 8'h00);
        chk(d, `REVISION_CODE);
        acc(1'b1, 1'b1, 8'h01, 8'hFF);
        chk(d, `UNMAPPED_DATA);
        sup.pulse;
        chk({7'h00, READY}, 8'h00);
        chk(LOOP_RANGE, 8'h00);
        chk(pd[23:16], 8'h00);
        wait_ready;
        complete_run;
    end
endmodule
